// ===== core/tdmfc_router.v
`timescale 1ns/1ps
`include "tdmfc_map.vh"
module tdmfc_router #(
  parameter FRAME_CYC = `TDMFC_FRAME_NS / `TDMFC_CLK_NS
) (
  input  wire        i_mclk,
  input  wire        i_arst_n,
  input  wire [7:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  input  wire [3:0]  i_avs_byteenable,
  output reg  [31:0] o_avs_readdata,
  output reg         o_avs_waitrequest,
  output reg         o_frame,
  output reg         o_fifo_req,
  output reg  [4:0]  o_fifo_num,
  output reg         o_fifo_dir,
  input  wire        i_fifo_rd_vld,
  input  wire [7:0]  i_fifo_rd_data,
  output reg         o_fifo_wr,
  output reg  [7:0]  o_fifo_wr_data,
  input  wire [2:0]  i_st_tx_if,
  input  wire [1:0]  i_st_tx_code,
  output reg  [7:0]  o_st_tx_data,
  input  wire        i_st_rx_we,
  input  wire [2:0]  i_st_rx_if,
  input  wire [1:0]  i_st_rx_code,
  input  wire [7:0]  i_st_rx_data,
  input  wire [4:0]  i_pcm_tx_ch,
  output reg  [7:0]  o_pcm_tx_data,
  input  wire        i_pcm_rx_we,
  input  wire [4:0]  i_pcm_rx_ch,
  input  wire [7:0]  i_pcm_rx_data
);

  localparam ST_IDLE = 1'b0;
  localparam ST_RUN  = 1'b1;
  localparam [31:0] FRAME_LAST = FRAME_CYC - 1;

  // Four switching buffers, three banks of 32 channels each
  reg [7:0] st_tx  [0:`TDMFC_BUF_DEPTH-1]; // R10
  reg [7:0] st_rx  [0:`TDMFC_BUF_DEPTH-1];
  reg [7:0] pcm_tx [0:`TDMFC_BUF_DEPTH-1];
  reg [7:0] pcm_rx [0:`TDMFC_BUF_DEPTH-1];

  reg [2:0]  cfg_tx_q [0:`TDMFC_NUM_FIFO-1];
  reg [2:0]  cfg_rx_q [0:`TDMFC_NUM_FIFO-1];
  reg [4:0]  chan_q   [0:`TDMFC_NUM_FIFO-1];
  reg [2:0]  ctrl_q;
  reg [5:0]  sel_q;
  reg        ovr_q;
  reg [31:0] cnt_q;
  reg [1:0]  fb_q;
  reg        conf_q;
  reg        state_q;
  reg [5:0]  idx_q;
  reg        ph_q;
  reg        act_q;
  reg [4:0]  last_d;
  reg [31:0] rd_d;

  function [1:0] bdec;
    input [1:0] b;
    begin
      bdec = (b == 2'h0) ? 2'h2 : b - 2'h1;
    end
  endfunction

  wire       tick   = (cnt_q == FRAME_LAST);
  // Data cycle of an entry: the FIFO answers one cycle after its request
  wire       act    = act_q;
  wire [4:0] ch     = chan_q[o_fifo_num]; // R9
  wire [2:0] fld    = o_fifo_dir ? cfg_rx_q[o_fifo_num] : cfg_tx_q[o_fifo_num];
  wire [1:0] rbank  = bdec(fb_q);
  wire [6:0] wa     = {fb_q, ch};
  wire [6:0] ra     = {rbank, ch};
  wire [1:0] tbank  = conf_q ? bdec(rbank) : rbank; // R5
  wire [4:0] sel_f  = sel_q[4:0];
  wire       req    = i_avs_read | i_avs_write;
  wire       wr_go  = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
  wire       tx_go  = act && !o_fifo_dir;
  wire       rx_go  = act && o_fifo_dir;
  wire       wr_ctrl = wr_go && (i_avs_address == `TDMFC_ADDR_CTRL);
  wire       wr_sel  = wr_go && (i_avs_address == `TDMFC_ADDR_FIFO_SEL);
  wire       wr_cfg  = wr_go && (i_avs_address == `TDMFC_ADDR_CON_CFG);
  wire       wr_chan = wr_go && (i_avs_address == `TDMFC_ADDR_CHAN);
  wire       wr_stat = wr_go && (i_avs_address == `TDMFC_ADDR_STATUS);
  wire [2:0] cfg_sel = sel_q[`TDMFC_SEL_DIR] ? cfg_rx_q[sel_f] : cfg_tx_q[sel_f];

  always @* begin
    case (ctrl_q[`TDMFC_CTRL_SZ_HI:`TDMFC_CTRL_SZ_LO]) // R7
      2'h0:    last_d = `TDMFC_LAST_32;
      2'h1:    last_d = `TDMFC_LAST_16;
      2'h2:    last_d = `TDMFC_LAST_8;
      default: last_d = `TDMFC_LAST_4;
    endcase
  end

  // Frame timing and bank rotation
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_q   <= 32'h0000_0000;
      o_frame <= 1'b0;
      fb_q    <= 2'h0;
      conf_q  <= 1'b0;
    end else begin
      o_frame <= tick; // R23
      if (tick) begin
        cnt_q  <= 32'h0000_0000;
        fb_q   <= (fb_q == 2'h2) ? 2'h0 : fb_q + 2'h1; // R1
        conf_q <= ctrl_q[`TDMFC_CTRL_CONF];
      end else begin
        cnt_q <= cnt_q + 32'h0000_0001;
      end
    end
  end

  // Service sequencer: two cycles per entry, TX then RX per FIFO
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q    <= ST_IDLE;
      idx_q      <= 6'h00;
      ph_q       <= 1'b0;
      o_fifo_req <= 1'b0;
      o_fifo_num <= 5'h00;
      o_fifo_dir <= 1'b0;
      act_q      <= 1'b0;
    end else begin
      o_fifo_req <= 1'b0;
      act_q      <= o_fifo_req;
      if (tick) begin
        state_q <= ST_RUN;
        idx_q   <= 6'h00;
        ph_q    <= 1'b0;
      end else begin
        case (state_q)
          ST_RUN: begin
            if (!ph_q) begin
              o_fifo_req <= 1'b1;
              o_fifo_num <= idx_q[5:1]; // R6
              o_fifo_dir <= idx_q[0];
              ph_q       <= 1'b1;
            end else begin
              ph_q  <= 1'b0;
              idx_q <= idx_q + 6'h01;
              if (idx_q == {last_d, 1'b1})
                state_q <= ST_IDLE;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Interface-side captures land in the bank open this frame
  always @(posedge i_mclk) begin
    if (i_st_rx_we)
      st_rx[{fb_q, i_st_rx_if, i_st_rx_code}] <= i_st_rx_data; // R21 R22
  end

  always @(posedge i_mclk) begin
    if (i_pcm_rx_we)
      pcm_rx[{fb_q, i_pcm_rx_ch}] <= i_pcm_rx_data; // R22
  end

  // Transmit entries pick the PCM source; S/T source uses the same channel
  always @(posedge i_mclk) begin
    if (tx_go) begin
      if (fld[`TDMFC_FLD_TX_ST_PCM])
        pcm_tx[wa] <= st_rx[ra]; // R13 R14
      else if (i_fifo_rd_vld)
        pcm_tx[wa] <= i_fifo_rd_data; // R15
    end
  end

  // Two writers for S/T transmit; the later entry in service order wins
  always @(posedge i_mclk) begin
    if (tx_go && !fld[`TDMFC_FLD_TX_NO_ST] && i_fifo_rd_vld)
      st_tx[wa] <= i_fifo_rd_data; // R12
    else if (rx_go && fld[`TDMFC_FLD_RX_FWD])
      st_tx[wa] <= pcm_rx[ra]; // R8 R17 R18
  end

  // FIFO write-back and interface-side reads
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_fifo_wr      <= 1'b0;
      o_fifo_wr_data <= 8'h00;
      o_st_tx_data   <= 8'h00;
      o_pcm_tx_data  <= 8'h00;
    end else begin
      o_fifo_wr <= rx_go; // R3
      if (rx_go)
        o_fifo_wr_data <= fld[`TDMFC_FLD_RX_PCM] ? pcm_rx[ra] : st_rx[ra]; // R16
      o_st_tx_data  <= st_tx[{tbank, i_st_tx_if, i_st_tx_code}]; // R2
      o_pcm_tx_data <= pcm_tx[{tbank, i_pcm_tx_ch}]; // R4
    end
  end

  // Read data selection; unmapped addresses read zero
  always @* begin
    rd_d = 32'h0000_0000;
    case (i_avs_address)
      `TDMFC_ADDR_CTRL:     rd_d[2:0] = ctrl_q;
      `TDMFC_ADDR_FIFO_SEL: rd_d[5:0] = sel_q;
      `TDMFC_ADDR_CON_CFG:  rd_d[2:0] = cfg_sel;
      `TDMFC_ADDR_CHAN:     rd_d[4:0] = chan_q[sel_f];
      `TDMFC_ADDR_STATUS:   rd_d[4:0] = {conf_q, fb_q, ovr_q, state_q};
      default:              rd_d = 32'h0000_0000;
    endcase
  end

  // Register slave: one wait cycle, write commits when waitrequest is low
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h0000_0000;
    end else begin
      o_avs_waitrequest <= !(req && o_avs_waitrequest);
      if (i_avs_read && o_avs_waitrequest)
        o_avs_readdata <= rd_d;
    end
  end

  // Control, FIFO select and sticky overrun flag
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_q <= `TDMFC_CTRL_RST;
      sel_q  <= 6'h00;
      ovr_q  <= 1'b0;
    end else begin
      if (wr_ctrl)
        ctrl_q <= i_avs_writedata[2:0];
      if (wr_sel)
        sel_q <= i_avs_writedata[5:0]; // R11
      // Frame boundary while still servicing: set beats clear
      if (tick && state_q == ST_RUN)
        ovr_q <= 1'b1; // R23
      else if (wr_stat && i_avs_writedata[`TDMFC_STAT_OVR])
        ovr_q <= 1'b0;
    end
  end

  // Per-FIFO routing table: one field per direction and the assigned channel
  genvar g;
  generate
    for (g = 0; g < `TDMFC_NUM_FIFO; g = g + 1) begin : g_route
      localparam [4:0] CH_RST = g;
      always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          cfg_tx_q[g] <= `TDMFC_CFG_RST;
          cfg_rx_q[g] <= `TDMFC_CFG_RST;
          chan_q[g]   <= CH_RST; // R9
        end else if (sel_f == CH_RST) begin
          if (wr_cfg && !sel_q[`TDMFC_SEL_DIR])
            cfg_tx_q[g] <= i_avs_writedata[2:0];
          if (wr_cfg && sel_q[`TDMFC_SEL_DIR])
            cfg_rx_q[g] <= i_avs_writedata[2:0];
          if (wr_chan)
            chan_q[g] <= i_avs_writedata[4:0];
        end
      end
    end
  endgenerate

endmodule

// ===== include/tdmfc_map.vh
// Notes on behaviour
// R1: Each switching buffer rotates its three banks one step at every frame boundary.
// R2: A transmit FIFO byte placed in a buffer goes out during the next frame.
// R3: A captured receive byte reaches its receive FIFO in the following frame.
// R4: Direct PCM and S/T routes delay two frames: capture, copy, then send.
// R5: With conference enabled, every routed transmit byte waits one extra frame.
// R6: Each frame services FIFOs ascending, transmit before receive, at most 64 entries.
// R7: Highest serviced FIFO follows the size setting: 31, 15, 7 or 3.
// R8: Several writes to one buffer entry in a frame: the last one wins.
// R9: Routing field is kept per FIFO but acts on the FIFO's assigned channel.
// R10: Four switching buffers (S/T and PCM, each direction) and three source switches.
// R11: Software picks FIFO direction, 0 transmit 1 receive, before writing its routing.
// R12: Transmit: FIFO byte goes to S/T transmit only when routing bit 1 is zero.
// R13: Transmit: routing bit 2 picks PCM source, 0 FIFO byte, 1 S/T receive.
// R14: The S/T receive source for PCM uses the same channel number.
// R15: Transmit: routing bit 0 has no effect.
// R16: Receive: routing bit 0 picks FIFO source, 0 S/T receive, 1 PCM receive.
// R17: Receive: routing bit 1 also forwards PCM receive byte to S/T transmit.
// R18: Receive: routing bit 2 has no effect.
// R19: Software should use 000 for FIFO-S/T, 001 for FIFO-PCM, 110 for S/T-PCM.
// R20: Software should use 100 for FIFO-to-S/T when tone detection is needed.
// R21: Channel number equals S/T interface index times four plus channel code.
// R22: Each S/T channel and PCM slot carries one byte per frame.
// R23: A one-cycle frame strobe marks boundaries; all entries finish between strobes.
`ifndef TDMFC_MAP_VH
`define TDMFC_MAP_VH

`define TDMFC_CLK_NS        25
`define TDMFC_FRAME_NS      125000

`define TDMFC_ADDR_CTRL     8'h00
`define TDMFC_ADDR_FIFO_SEL 8'h04
`define TDMFC_ADDR_CON_CFG  8'h08
`define TDMFC_ADDR_CHAN     8'h0C
`define TDMFC_ADDR_STATUS   8'h10

`define TDMFC_CTRL_SZ_LO    0
`define TDMFC_CTRL_SZ_HI    1
`define TDMFC_CTRL_CONF     2
`define TDMFC_SEL_DIR       5
`define TDMFC_STAT_OVR      1

`define TDMFC_FLD_TX_NO_ST  1
`define TDMFC_FLD_TX_ST_PCM 2
`define TDMFC_FLD_RX_PCM    0
`define TDMFC_FLD_RX_FWD    1

`define TDMFC_LAST_32       5'h1F
`define TDMFC_LAST_16       5'h0F
`define TDMFC_LAST_8        5'h07
`define TDMFC_LAST_4        5'h03

`define TDMFC_CTRL_RST      3'h0
`define TDMFC_CFG_RST       3'h0
`define TDMFC_NUM_FIFO      32
`define TDMFC_BUF_DEPTH     96

`endif

// ===== tb/tdmfc_fifo_model.sv
`timescale 1ns/1ps
module tdmfc_fifo_model (
  input  wire        i_mclk,
  input  wire        i_req,
  input  wire        i_dir,
  input  wire  [4:0] i_num,
  input  wire  [7:0] i_byte,
  input  wire        i_wr,
  input  wire  [7:0] i_wr_data,
  output logic       o_vld,
  output logic [7:0] o_data
);
  logic [7:0] mem [32];
  logic [4:0] wnum_q;
  initial begin
    o_vld = 1'b0;
    o_data = 8'h00;
  end
  // Answer a transmit entry next cycle; otherwise the data line toggles
  always @(posedge i_mclk) begin
    o_vld <= i_req && !i_dir;
    o_data <= (i_req && !i_dir) ? i_byte : ~o_data;
    if (i_req && i_dir) wnum_q <= i_num;
    if (i_wr) mem[wnum_q] <= i_wr_data;
  end
endmodule

// ===== tb/tdmfc_router_asserts.sv
`timescale 1ns/1ps
module tdmfc_router_chk (
  input wire       i_mclk,
  input wire       i_arst_n,
  input wire       i_avs_read,
  input wire       i_avs_write,
  input wire       o_avs_waitrequest,
  input wire       o_frame,
  input wire       o_fifo_req,
  input wire [4:0] o_fifo_num,
  input wire       o_fifo_dir,
  input wire       o_fifo_wr
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  logic [7:0] cnt_q;
  // Cycles since the last strobe, saturating
  always @(posedge i_mclk or negedge i_arst_n)
    if (!i_arst_n) cnt_q <= 8'h00;
    else cnt_q <= o_frame ? 8'h00 : cnt_q + {7'h00, cnt_q != 8'hFF};
  a_frame_pulse: assert property (o_frame |=> !o_frame) else $error("strobe long");
  a_first_entry: assert property (o_frame |=> o_fifo_req && o_fifo_num == 5'h00 && !o_fifo_dir)
    else $error("first entry wrong");
  a_tx_then_rx: assert property (o_fifo_req && !o_fifo_dir |-> ##2 o_fifo_req && o_fifo_dir &&
    o_fifo_num == $past(o_fifo_num, 2)) else $error("rx entry missing");
  a_rx_next_tx: assert property (o_fifo_req && o_fifo_dir |-> ##2 !o_fifo_req ||
    (!o_fifo_dir && o_fifo_num == $past(o_fifo_num, 2) + 5'h01)) else $error("order wrong");
  a_rx_write: assert property (o_fifo_req && o_fifo_dir |-> ##2 o_fifo_wr) else $error("no rx wr");
  a_wr_cause: assert property (o_fifo_wr |-> $past(o_fifo_req, 2) && $past(o_fifo_dir, 2))
    else $error("stray rx wr");
  a_in_window: assert property (o_fifo_req |-> cnt_q < 8'h82) else $error("late entry");
  a_bus_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=>
    !o_avs_waitrequest) else $error("bus no answer");
  a_wait_once: assert property (!o_avs_waitrequest |=> o_avs_waitrequest) else $error("wait low");
  cover property (o_fifo_wr);
  cover property (o_fifo_req && o_fifo_num == 5'h1F);
  cover property (!o_avs_waitrequest && i_avs_write);
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int FC = 200;
  logic i_mclk = 1'b0, i_arst_n = 1'b0, rd = 1'b0, wr = 1'b0, st_we = 1'b0, pcm_we = 1'b0;
  logic [7:0] adr = 8'h00, tb_byte = 8'h00, rx_data = 8'h00;
  logic [31:0] wd = 32'h0000_0000, rdv;
  logic [4:0] st_rx_ch = 5'h00, st_tx_ch = 5'h00, pcm_rx_ch = 5'h00, pcm_tx_ch = 5'h00;
  wire [31:0] rdata;
  wire wq, frm, req, dir, vld, fwr;
  wire [4:0] num;
  wire [7:0] fdat, wdat, st_tx, pcm_tx;
  int miscompares = 0, cmp_count = 0;
  always #12.5 i_mclk = ~i_mclk;
  tdmfc_router #(.FRAME_CYC(FC)) DUT (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wq), .o_frame(frm), .o_fifo_req(req),
    .o_fifo_num(num), .o_fifo_dir(dir), .i_fifo_rd_vld(vld), .i_fifo_rd_data(fdat),
    .o_fifo_wr(fwr), .o_fifo_wr_data(wdat), .i_st_tx_if(st_tx_ch[4:2]),
    .i_st_tx_code(st_tx_ch[1:0]), .o_st_tx_data(st_tx), .i_st_rx_we(st_we),
    .i_st_rx_if(st_rx_ch[4:2]), .i_st_rx_code(st_rx_ch[1:0]), .i_st_rx_data(rx_data),
    .i_pcm_tx_ch(pcm_tx_ch), .o_pcm_tx_data(pcm_tx), .i_pcm_rx_we(pcm_we),
    .i_pcm_rx_ch(pcm_rx_ch), .i_pcm_rx_data(rx_data));
  tdmfc_fifo_model u_fifo (.i_mclk(i_mclk), .i_req(req), .i_dir(dir), .i_num(num),
    .i_byte(tb_byte), .i_wr(fwr), .i_wr_data(wdat), .o_vld(vld), .o_data(fdat));
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tmo;
    miscompares++;
    finish_test;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    adr <= a; wd <= d; wr <= w; rd <= !w;
    do begin @(posedge i_mclk); n++; end while (wq !== 1'b0 && n < 20);
    rdv = rdata; wr <= 1'b0; rd <= 1'b0;
    if (n >= 20) tmo;
    @(posedge i_mclk);
  endtask
  task automatic cfg(input logic [4:0] n, input logic d, input logic [2:0] f);
    acc(1'b1, 8'h04, {26'h0, d, n});
    acc(1'b1, 8'h08, {29'h0, f});
  endtask
  task automatic nf;
    int n = 0;
    do begin @(posedge i_mclk); n++; end while (frm !== 1'b1 && n < 400);
    if (n >= 400) tmo;
  endtask
  task automatic cap(input logic st, input logic [4:0] ch, input logic [7:0] d);
    st_we <= st; pcm_we <= !st; st_rx_ch <= ch; pcm_rx_ch <= ch; rx_data <= d;
    @(posedge i_mclk);
    st_we <= 1'b0; pcm_we <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic txc(input logic st, input logic [4:0] ch, input logic [7:0] e, input string nm);
    st_tx_ch <= ch; pcm_tx_ch <= ch;
    repeat (2) @(posedge i_mclk);
    check(nm, st ? st_tx : pcm_tx, e);
  endtask
  task automatic t_regs;
    acc(1'b0, 8'h00, 32'h0000_0000); check("ctrl", rdv, 32'h0000_0000);
    acc(1'b0, 8'h20, 32'h0000_0000); check("unmapped", rdv, 32'h0000_0000);
  endtask
  task automatic t_paths;
    cfg(5'h05, 1'b0, 3'h1); cfg(5'h06, 1'b0, 3'h5);
    cfg(5'h05, 1'b1, 3'h4); cfg(5'h06, 1'b1, 3'h3);
    cfg(5'h07, 1'b0, 3'h4);
    tb_byte <= 8'h11; nf;
    cap(1'b1, 5'h05, 8'h22); cap(1'b1, 5'h06, 8'h33); cap(1'b0, 5'h06, 8'h44);
    tb_byte <= 8'h66; nf; nf;
    txc(1'b1, 5'h05, 8'h66, "st5");
    txc(1'b0, 5'h05, 8'h66, "pcm5");
    txc(1'b0, 5'h06, 8'h33, "pcm6");
    txc(1'b1, 5'h06, 8'h44, "st6");
    txc(1'b1, 5'h07, 8'h66, "st7");
    check("rx5", u_fifo.mem[5], 8'h22);
    check("rx6", u_fifo.mem[6], 8'h44);
  endtask
  task automatic t_conf;
    acc(1'b1, 8'h04, 32'h0000_0005); acc(1'b1, 8'h0C, 32'h0000_0009);
    acc(1'b1, 8'h00, 32'h0000_0004);
    tb_byte <= 8'h77; nf; repeat (150) @(posedge i_mclk);
    tb_byte <= 8'h88; nf; nf;
    txc(1'b1, 5'h09, 8'h77, "conf st9");
    acc(1'b1, 8'h00, 32'h0000_0000);
  endtask
  task automatic t_size;
    int c;
    for (int s = 3; s >= 0; s--) begin
      acc(1'b1, 8'h00, s); nf; c = 0;
      repeat (150) begin @(posedge i_mclk); c += (req === 1'b1); end
      check("entries", c, 64 >> s);
    end
  endtask
  initial begin
    repeat (20) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    @(posedge i_mclk);
    t_regs; t_paths; t_conf; t_size;
    finish_test;
  end
endmodule
bind tdmfc_router tdmfc_router_chk u_chk (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
  .o_frame(o_frame), .o_fifo_req(o_fifo_req), .o_fifo_num(o_fifo_num),
  .o_fifo_dir(o_fifo_dir), .o_fifo_wr(o_fifo_wr));
